// file: plmm_map.vh
// address map, field layout, reset values and codes of the memory mapper
`ifndef PLMM_MAP_VH
`define PLMM_MAP_VH

// register byte offsets on the AXI4-Lite port
`define OFS_PAGE_SELECT   5'h00
`define OFS_PTR_HIGH      5'h04
`define OFS_PTR_MID       5'h08
`define OFS_PTR_LOW       5'h0c
`define OFS_WORD_INCR     5'h10
`define OFS_BYTE_INCR     5'h14
`define OFS_BYTE_PORT     5'h18
`define OFS_PTR_ADD       5'h1c

// implemented widths
`define PAGE_BITS         3
`define PTR_BITS          17
`define WIN_OFS_BITS      14

// paging window is processor address 0x8000-0xbfff
`define WIN_SEL           2'b10

// reset values
`define PAGE_RESET        3'h2
`define PTR_RESET         17'h00000

// AXI responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// file: paged_linear_memory_mapper.v
// paged window translation and linear pointer data ports behind AXI4-Lite
//
// Operation
// - window accesses go to page-selected 16K block
// - every reset loads page select with two
// - window address is page above A13:A0
// - page select readable and writable by processor
// - 17-bit pointer addresses all three data ports
// - plain port read returns byte, pointer kept
// - plain port write stores byte, pointer kept
// - increment port read returns byte, then increments
// - increment port write stores byte, then increments
// - word and byte increment ports behave alike
// - add port adds sign-extended byte to pointer
// - add port reads zero, resets to zero

`include "plmm_map.vh"

module paged_linear_memory_mapper #(
  parameter ADDR_WIDTH = 16,
  parameter DATA_WIDTH = 8
) (
  input  wire                   clock_i,
  input  wire                   rst_n_i,
  // AXI4-Lite slave
  input  wire [31:0]            s_axi_awaddr_i,
  input  wire                   s_axi_awvalid_i,
  output wire                   s_axi_awready_o,
  input  wire [31:0]            s_axi_wdata_i,
  input  wire [3:0]             s_axi_wstrb_i,
  input  wire                   s_axi_wvalid_i,
  output wire                   s_axi_wready_o,
  output wire [1:0]             s_axi_bresp_o,
  output wire                   s_axi_bvalid_o,
  input  wire                   s_axi_bready_i,
  input  wire [31:0]            s_axi_araddr_i,
  input  wire                   s_axi_arvalid_i,
  output wire                   s_axi_arready_o,
  output wire [31:0]            s_axi_rdata_o,
  output wire [1:0]             s_axi_rresp_o,
  output wire                   s_axi_rvalid_o,
  input  wire                   s_axi_rready_i,
  // processor address translation
  input  wire [ADDR_WIDTH-1:0]  cpu_addr_i,
  output wire [`PTR_BITS-1:0]   ext_addr_o,
  output wire                   window_hit_o,
  // extended memory port for linear accesses
  output wire                   mem_req_o,
  output wire                   mem_we_o,
  output wire [`PTR_BITS-1:0]   mem_addr_o,
  output wire [DATA_WIDTH-1:0]  mem_wdata_o,
  input  wire [DATA_WIDTH-1:0]  mem_rdata_i,
  input  wire                   mem_ack_i
);

  // bus state machine codes
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WMEM  = 3'h1;
  localparam [2:0] ST_RMEM  = 3'h2;
  localparam [2:0] ST_BRESP = 3'h3;
  localparam [2:0] ST_RRESP = 3'h4;

  reg [`PAGE_BITS-1:0]  page_select;
  reg [`PTR_BITS-1:0]   pointer;
  reg [`PTR_BITS-1:0]   ext_addr;
  reg                   window_hit;

  reg [2:0]             state;
  reg                   aw_full;
  reg                   w_full;
  reg                   ar_full;
  reg [4:0]             aw_ofs;
  reg                   aw_ok;
  reg [DATA_WIDTH-1:0]  w_byte;
  reg                   w_lane0;
  reg [4:0]             ar_ofs;
  reg                   ar_ok;
  reg                   bvalid;
  reg [1:0]             bresp;
  reg                   rvalid;
  reg [1:0]             rresp;
  reg [31:0]            rdata;
  reg                   mem_req;
  reg                   mem_we;
  reg [`PTR_BITS-1:0]   mem_addr;
  reg [DATA_WIDTH-1:0]  mem_wdata;
  reg                   mem_incr;
  reg                   awready;
  reg                   wready;
  reg                   arready;

  wire [DATA_WIDTH-1:0] page_rd;
  wire [DATA_WIDTH-1:0] ptr_high_rd;
  wire [DATA_WIDTH-1:0] ptr_mid_rd;
  wire [DATA_WIDTH-1:0] ptr_low_rd;
  wire [`PTR_BITS-1:0]  add_ext;
  wire [`PTR_BITS-1:0]  ptr_plus_one;
  wire                  w_is_data;
  wire                  w_is_incr;
  wire                  r_is_data;
  wire                  r_is_incr;
  wire                  aw_take;
  wire                  w_take;
  wire                  ar_take;
  reg  [DATA_WIDTH-1:0] reg_rd;

  // unimplemented page and pointer bits read as zero
  assign page_rd = {{(DATA_WIDTH-`PAGE_BITS){1'b0}},
                    page_select};
  assign ptr_high_rd = {{(DATA_WIDTH-1){1'b0}},
                        pointer[16]};
  assign ptr_mid_rd = pointer[15:8];
  assign ptr_low_rd = pointer[7:0];

  // sign-extended addend; 17-bit width gives the modulo wrap
  assign add_ext = {{(`PTR_BITS-DATA_WIDTH){w_byte[DATA_WIDTH-1]}},
                    w_byte};
  assign ptr_plus_one = pointer + 17'h00001;

  // both increment ports decode to the same behaviour
  assign w_is_incr = (aw_ofs == `OFS_WORD_INCR) ||
                     (aw_ofs == `OFS_BYTE_INCR);
  assign w_is_data = w_is_incr || (aw_ofs == `OFS_BYTE_PORT);
  assign r_is_incr = (ar_ofs == `OFS_WORD_INCR) ||
                     (ar_ofs == `OFS_BYTE_INCR);
  assign r_is_data = r_is_incr || (ar_ofs == `OFS_BYTE_PORT);

  assign aw_take = s_axi_awvalid_i && !aw_full;
  assign w_take  = s_axi_wvalid_i && !w_full;
  assign ar_take = s_axi_arvalid_i && !ar_full;

  // register read mux for the non-memory registers
  always @* begin
    reg_rd = {DATA_WIDTH{1'b0}};
    case (ar_ofs)
      `OFS_PAGE_SELECT: reg_rd = page_rd;
      `OFS_PTR_HIGH:    reg_rd = ptr_high_rd;
      `OFS_PTR_MID:     reg_rd = ptr_mid_rd;
      `OFS_PTR_LOW:     reg_rd = ptr_low_rd;
      `OFS_PTR_ADD:     reg_rd = {DATA_WIDTH{1'b0}};
      default:          reg_rd = {DATA_WIDTH{1'b0}};
    endcase
  end

  // processor window translation, one cycle of latency
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      ext_addr   <= {`PTR_BITS{1'b0}};
      window_hit <= 1'b0;
    end else if (cpu_addr_i[15:14] == `WIN_SEL) begin
      ext_addr   <= {page_select,
                     cpu_addr_i[`WIN_OFS_BITS-1:0]};
      window_hit <= 1'b1;
    end else begin
      ext_addr   <= {1'b0, cpu_addr_i[15:0]};
      window_hit <= 1'b0;
    end
  end

  // address and data capture; write address and data in either order
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      aw_full <= 1'b0;
      aw_ofs  <= 5'h00;
      aw_ok   <= 1'b0;
      w_full  <= 1'b0;
      w_byte  <= {DATA_WIDTH{1'b0}};
      w_lane0 <= 1'b0;
      ar_full <= 1'b0;
      ar_ofs  <= 5'h00;
      ar_ok   <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_ofs  <= s_axi_awaddr_i[4:0];
        aw_ok   <= (s_axi_awaddr_i[31:5] == 27'h0000000) &&
                   (s_axi_awaddr_i[1:0] == 2'b00);
      end else if (bvalid && s_axi_bready_i) begin
        aw_full <= 1'b0;
      end
      if (w_take) begin
        w_full  <= 1'b1;
        w_byte  <= s_axi_wdata_i[DATA_WIDTH-1:0];
        w_lane0 <= s_axi_wstrb_i[0];
      end else if (bvalid && s_axi_bready_i) begin
        w_full  <= 1'b0;
      end
      if (ar_take) begin
        ar_full <= 1'b1;
        ar_ofs  <= s_axi_araddr_i[4:0];
        ar_ok   <= (s_axi_araddr_i[31:5] == 27'h0000000) &&
                   (s_axi_araddr_i[1:0] == 2'b00);
      end else if (rvalid && s_axi_rready_i) begin
        ar_full <= 1'b0;
      end
    end
  end

  // ready flags live in their own flip-flops so no gate sits before a port
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      awready <= 1'b1;
    end else if (aw_take) begin
      awready <= 1'b0;
    end else if (bvalid && s_axi_bready_i) begin
      awready <= 1'b1;
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      wready <= 1'b1;
    end else if (w_take) begin
      wready <= 1'b0;
    end else if (bvalid && s_axi_bready_i) begin
      wready <= 1'b1;
    end
  end

  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      arready <= 1'b1;
    end else if (ar_take) begin
      arready <= 1'b0;
    end else if (rvalid && s_axi_rready_i) begin
      arready <= 1'b1;
    end
  end

  // one transfer at a time; a pending write is served before a read
  always @(posedge clock_i) begin
    if (!rst_n_i) begin
      state       <= ST_IDLE;
      page_select <= `PAGE_RESET;
      pointer     <= `PTR_RESET;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OKAY;
      rvalid      <= 1'b0;
      rresp       <= `RESP_OKAY;
      rdata       <= 32'h00000000;
      mem_req     <= 1'b0;
      mem_we      <= 1'b0;
      mem_addr    <= {`PTR_BITS{1'b0}};
      mem_wdata   <= {DATA_WIDTH{1'b0}};
      mem_incr    <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (aw_full && w_full) begin
            bresp <= aw_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_ok && w_lane0 && w_is_data) begin
              // pointer is held while the memory cycle runs
              mem_req   <= 1'b1;
              mem_we    <= 1'b1;
              mem_addr  <= pointer;
              mem_wdata <= w_byte;
              mem_incr  <= w_is_incr;
              state     <= ST_WMEM;
            end else begin
              if (aw_ok && w_lane0) begin
                case (aw_ofs)
                  `OFS_PAGE_SELECT:
                    page_select <= w_byte[`PAGE_BITS-1:0];
                  `OFS_PTR_HIGH:
                    pointer[16] <= w_byte[0];
                  `OFS_PTR_MID:
                    pointer[15:8] <= w_byte;
                  `OFS_PTR_LOW:
                    pointer[7:0] <= w_byte;
                  `OFS_PTR_ADD:
                    pointer <= pointer + add_ext;
                  default: begin
                  end
                endcase
              end
              bvalid <= 1'b1;
              state  <= ST_BRESP;
            end
          end else if (ar_full) begin
            rresp <= ar_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (ar_ok && r_is_data) begin
              mem_req  <= 1'b1;
              mem_we   <= 1'b0;
              mem_addr <= pointer;
              mem_incr <= r_is_incr;
              state    <= ST_RMEM;
            end else begin
              rdata  <= ar_ok ? {24'h000000, reg_rd} : 32'h00000000;
              rvalid <= 1'b1;
              state  <= ST_RRESP;
            end
          end
        end
        ST_WMEM: begin
          if (mem_ack_i) begin
            mem_req <= 1'b0;
            // increment only after the store is acknowledged
            if (mem_incr) begin
              pointer <= ptr_plus_one;
            end
            bvalid <= 1'b1;
            state  <= ST_BRESP;
          end
        end
        ST_RMEM: begin
          if (mem_ack_i) begin
            mem_req <= 1'b0;
            rdata   <= {24'h000000, mem_rdata_i};
            if (mem_incr) begin
              pointer <= ptr_plus_one;
            end
            rvalid <= 1'b1;
            state  <= ST_RRESP;
          end
        end
        ST_BRESP: begin
          if (s_axi_bready_i) begin
            bvalid <= 1'b0;
            state  <= ST_IDLE;
          end
        end
        ST_RRESP: begin
          if (s_axi_rready_i) begin
            rvalid <= 1'b0;
            state  <= ST_IDLE;
          end
        end
        default: begin
          mem_req <= 1'b0;
          state   <= ST_IDLE;
        end
      endcase
    end
  end

  // every port is driven straight from a flip-flop
  assign s_axi_awready_o = awready;
  assign s_axi_wready_o  = wready;
  assign s_axi_arready_o = arready;
  assign s_axi_bvalid_o  = bvalid;
  assign s_axi_bresp_o   = bresp;
  assign s_axi_rvalid_o  = rvalid;
  assign s_axi_rresp_o   = rresp;
  assign s_axi_rdata_o   = rdata;
  assign ext_addr_o      = ext_addr;
  assign window_hit_o    = window_hit;
  assign mem_req_o       = mem_req;
  assign mem_we_o        = mem_we;
  assign mem_addr_o      = mem_addr;
  assign mem_wdata_o     = mem_wdata;

endmodule // paged_linear_memory_mapper

// file: plmm_properties.sv
// port assertions for the paged linear memory mapper
module plmm_properties (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [16:0] ext_addr_o,
  input wire logic        window_hit_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [16:0] mem_addr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic [7:0]  mem_rdata_i,
  input wire logic        mem_ack_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] rd_ofs;
  logic [7:0] w_byte;
  logic       win;
  assign win = cpu_addr_i[15:14] == 2'b10;
  // only one read and one write outstanding, so one capture each suffices
  always @(posedge clock_i) begin
    if (s_axi_arvalid_i && s_axi_arready_o) rd_ofs <= s_axi_araddr_i[4:0];
    if (s_axi_wvalid_i && s_axi_wready_o) w_byte <= s_axi_wdata_i[7:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  chk_window_hit: assert property (win |=> window_hit_o)
    else $error("window access not flagged");
  chk_window_offset: assert property (win |=>
    ext_addr_o[13:0] == $past(cpu_addr_i[13:0]))
    else $error("window offset not kept");
  chk_flat_pass: assert property (!win |=>
    ext_addr_o == {1'b0, $past(cpu_addr_i)} && !window_hit_o)
    else $error("address outside window altered");
  chk_reset_page: assert property (disable iff (1'b0)
    !rst_n_i ##1 (rst_n_i && win) |=> ext_addr_o[16:14] == 3'h2)
    else $error("page after reset is not two");
  chk_req_steady: assert property (mem_req_o && !mem_ack_i |=>
    mem_req_o && $stable(mem_addr_o) && $stable(mem_wdata_o))
    else $error("memory request changed before answer");
  chk_write_byte: assert property (mem_req_o && mem_we_o |->
    mem_wdata_o == w_byte)
    else $error("memory write byte differs from bus byte");
  chk_read_return: assert property (
    mem_req_o && mem_ack_i && !mem_we_o
    |=> s_axi_rvalid_o && s_axi_rdata_o == {24'h0, $past(mem_rdata_i)})
    else $error("memory byte not returned on bus");
  chk_add_zero: assert property (s_axi_rvalid_o && rd_ofs == 5'h1c
    |-> s_axi_rdata_o == 32'h0)
    else $error("add port read not zero");
  cover property (mem_req_o && mem_ack_i && mem_we_o);
  cover property (mem_req_o && mem_ack_i && !mem_we_o);
  cover property (win ##1 !win);
endmodule  // plmm_properties

// file: ext_mem_model.sv
// byte memory on the extended port, answering after a chosen delay
module ext_mem_model (
  input  wire logic        clock_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic [1:0]  delay_i,
  output logic      [7:0]  rdata_o,
  output logic             ack_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] store [0:131071];
  logic [1:0] cnt;
  initial begin
    for (int i = 0; i < 131072; i++) store[i] = 8'(i * 37 + (i >> 9));
    ack_o = 1'b0;
    rdata_o = 8'h5a;
    cnt = 2'h0;
  end
  always @(posedge clock_i) begin
    if (ack_o || !req_i) begin
      ack_o <= 1'b0;
      cnt <= 2'h0;
      // stale data must not look valid outside the answer cycle
      rdata_o <= ~rdata_o;
    end else if (cnt == delay_i) begin
      ack_o <= 1'b1;
      if (we_i) store[addr_i] <= wdata_i;
      else rdata_o <= store[addr_i];
    end else cnt <= cnt + 2'h1;
  end
endmodule  // ext_mem_model

// file: paged_linear_memory_mapper_bench.sv
// self-checking bench for the paged linear memory mapper
module paged_linear_memory_mapper_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0, rst_n_i = 1'b0;
  logic [31:0] s_axi_awaddr_i = 32'h0, s_axi_wdata_i = 32'h0;
  logic [31:0] s_axi_araddr_i = 32'h0, rdat;
  logic [3:0]  s_axi_wstrb_i = 4'h1;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0, s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0;
  logic [15:0] cpu_addr_i = 16'h8abc, a;
  wire logic   s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  wire logic   s_axi_arready_o, s_axi_rvalid_o, window_hit_o;
  wire logic   mem_req_o, mem_we_o, mem_ack_i;
  wire logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  wire logic [31:0] s_axi_rdata_o;
  wire logic [16:0] ext_addr_o, mem_addr_o;
  wire logic [7:0]  mem_wdata_o, mem_rdata_i;
  logic [1:0]  delay = 2'h0, resp;
  logic [16:0] ptr, want;
  logic [7:0]  d;
  logic [2:0]  pg;
  int          seed = 32'ha0f9, fail_count = 0, n_compared = 0;

  paged_linear_memory_mapper dut (.*);
  ext_mem_model mem (.clock_i(clock_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .delay_i(delay),
    .rdata_o(mem_rdata_i), .ack_o(mem_ack_i));

  always #2.5 clock_i = ~clock_i;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] ad, input logic [7:0] v);
    int n;
    @(posedge clock_i);
    n = 0;
    s_axi_awaddr_i <= ad;
    s_axi_wdata_i <= {$random(seed)} & 32'hffffff00 | {24'h0, v};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    delay <= 2'($random(seed));
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (!s_axi_bvalid_o && n < 300);
    s_axi_bready_i <= 1'b0;
    resp = s_axi_bresp_o;
    if (n >= 300) fail_count++;
  endtask

  task automatic rd(input logic [31:0] ad);
    int n;
    @(posedge clock_i);
    n = 0;
    s_axi_araddr_i <= ad;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    delay <= 2'($random(seed));
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (!s_axi_rvalid_o && n < 300);
    s_axi_rready_i <= 1'b0;
    rdat = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    if (n >= 300) fail_count++;
  endtask

  task automatic rd_ptr;
    rd(32'h04);
    check(rdat & 32'hfffffffe, 32'h0);
    ptr[16] = rdat[0];
    rd(32'h08);
    ptr[15:8] = rdat[7:0];
    rd(32'h0c);
    ptr[7:0] = rdat[7:0];
  endtask

  function automatic logic [16:0] exp_ext(logic [2:0] p, logic [15:0] x);
    return (x[15:14] == 2'b10) ? {p, x[13:0]} : {1'b0, x};
  endfunction

  task automatic close_out;
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    check(ext_addr_o, 17'h08abc);
    for (int i = 0; i < 5; i++) begin
      rd(i == 4 ? 32'h1c : 32'(i * 4));
      check(rdat, i == 0 ? 32'h2 : 32'h0);
    end
    rd(32'h20);
    check(resp, 2'b10);
    wr(32'h1e, 8'h33);
    check(resp, 2'b10);
    // a write with the low byte lane off must leave the page alone
    s_axi_wstrb_i <= 4'he;
    wr(32'h00, 8'h05);
    check(resp, 2'b00);
    s_axi_wstrb_i <= 4'h1;
    rd(32'h00);
    check(rdat, 32'h2);
    $display("reset and decode test done");
    for (int i = 0; i < 8; i++) begin
      pg = 3'($random(seed));
      wr(32'h00, 8'($random(seed)) & 8'hf8 | {5'h0, pg});
      check(resp, 2'b00);
      rd(32'h00);
      check(rdat, {29'h0, pg});
      for (int j = 0; j < 4; j++) begin
        a = 16'($random(seed));
        if (j == 0) a[15:14] = 2'b10;
        @(posedge clock_i);
        cpu_addr_i <= a;
        repeat (2) @(posedge clock_i);
        check(ext_addr_o, exp_ext(pg, a));
        check(window_hit_o, a[15:14] == 2'b10);
      end
    end
    $display("window test done");
    // a second reset in mid-run must bring the page back to two
    rst_n_i <= 1'b0;
    cpu_addr_i <= 16'hbfff;
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    check(ext_addr_o, 17'h0bfff);
    rd(32'h00);
    check(rdat, 32'h2);
    $display("mid-run reset test done");
    wr(32'h04, 8'h01);
    wr(32'h08, 8'hff);
    wr(32'h0c, 8'hfe);
    for (int i = 0; i < 2; i++) begin
      rd(32'h18);
      check(rdat, mem.store[17'h1fffe]);
    end
    rd(32'h10);
    check(rdat, mem.store[17'h1fffe]);
    rd(32'h14);
    check(rdat, mem.store[17'h1ffff]);
    rd_ptr;
    check(ptr, 17'h0);
    d = 8'($random(seed));
    wr(32'h18, d);
    check(mem.store[0], d);
    rd_ptr;
    check(ptr, 17'h0);
    wr(32'h10, ~d);
    wr(32'h14, d ^ 8'h5a);
    check(mem.store[0], 8'(~d));
    check(mem.store[1], d ^ 8'h5a);
    rd_ptr;
    check(ptr, 17'h2);
    $display("data port test done");
    want = 17'h2;
    for (int i = 0; i < 8; i++) begin
      d = i == 0 ? 8'h7f : i == 1 ? 8'hff : i == 2 ? 8'h80 : 8'($random(seed));
      want = want + {{9{d[7]}}, d};
      wr(32'h1c, d);
      rd_ptr;
      check(ptr, want);
    end
    $display("pointer add test done");
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clock_i);
    fail_count++;
    close_out;
  end
endmodule  // paged_linear_memory_mapper_bench

bind paged_linear_memory_mapper plmm_properties chk (.*);
